/* File: pkg/paged_add_consts.vh */
`ifndef PAGED_ADD_CONSTS_VH
`define PAGED_ADD_CONSTS_VH

// Word and address geometry
`define WORD_W        12
`define ADDR_W        12
`define FIELD_WORDS   4096
`define PAGE_COUNT    32
`define PAGE_WORDS    128
`define OFFSET_W      7
`define PAGE_W        5
`define ADDR_LAST     12'hfff

// Instruction bit positions (bit 0 is the lsb of the word)
`define IR_INDIRECT_POS  8
`define IR_CURPAGE_POS   7
`define IR_OFFSET_HI     6
`define IR_OFFSET_LO     0

// Operate codes for the sum-register micro-operations
`define OPC_INVERT_SUM     12'he20
`define OPC_INCREMENT_SUM  12'he01
`define OPR_INVERT_POS     5
`define OPR_INCREMENT_POS  0

// Reset values
`define SUM_RESET   12'h000
`define LINK_RESET  1'b0
`define ADDR_RESET  12'h000
`define FLAG_RESET  1'b0

`endif

/* File: verilog/paged_address_and_add_unit.v */
`timescale 1ns/1ps
`default_nettype none
`include "paged_add_consts.vh"

module paged_address_and_add_unit (
	// Clock and reset
	input  wire                  sys_clk_i,
	input  wire                  reset_n_i,
	// Instruction from the decoder
	input  wire                  mem_ref_start_i,
	input  wire                  add_enable_i,
	input  wire [`WORD_W-1:0]    instr_i,
	input  wire [`ADDR_W-1:0]    instr_addr_i,
	// Operate micro-operations
	input  wire                  operate_i,
	// Core memory read port
	output reg                   mem_read_o,
	output reg  [`ADDR_W-1:0]    mem_addr_o,
	input  wire                  mem_valid_i,
	input  wire [`WORD_W-1:0]    mem_data_i,
	// Results
	output reg  [`ADDR_W-1:0]    eff_addr_o,
	output reg                   eff_addr_valid_o,
	output reg  [`WORD_W-1:0]    sum_register_o,
	output reg                   link_o,
	output wire                  sum_negative_o,
	output wire                  busy_o
);

	localparam [2:0] ST_IDLE     = 3'd0;
	localparam [2:0] ST_PTR_READ = 3'd1;
	localparam [2:0] ST_OPR_READ = 3'd2;
	localparam [2:0] ST_INC      = 3'd3;

	// Sequencer
	reg  [2:0]          state;
	reg  [2:0]          next_state;
	reg                 add_pending;
	reg                 next_add_pending;

	// Next values of the registered outputs
	reg                 next_mem_read;
	reg  [`ADDR_W-1:0]  next_mem_addr;
	reg  [`ADDR_W-1:0]  next_eff_addr;
	reg                 next_eff_addr_valid;
	reg  [`WORD_W-1:0]  next_sum;
	reg                 next_link;

	// Decoded request and arithmetic
	wire                idle;
	wire                take_mem_ref;
	wire                take_operate;
	wire                want_indirect;
	wire                want_invert;
	wire                want_increment;
	wire [`ADDR_W-1:0]  page_addr;
	wire [`WORD_W:0]    add_full;
	wire                add_carry;
	wire [`WORD_W-1:0]  add_result;
	wire [`WORD_W-1:0]  inverted;
	wire [`WORD_W-1:0]  incremented;

	// Bits are numbered lsb-first on the word, so bit n is [n]
	function instr_indirect;
		input [`WORD_W-1:0] ir;
		begin
			instr_indirect = ir[`IR_INDIRECT_POS];
		end
	endfunction

	function instr_cur_page;
		input [`WORD_W-1:0] ir;
		begin
			instr_cur_page = ir[`IR_CURPAGE_POS];
		end
	endfunction

	// Sum with the carry out of the sign bit kept above it
	function [`WORD_W:0] add_words;
		input [`WORD_W-1:0] a;
		input [`WORD_W-1:0] b;
		begin
			add_words = {1'b0, a} + {1'b0, b};
		end
	endfunction

	// Page-formed address: page number over 7-bit offset
	function [`ADDR_W-1:0] form_page_addr;
		input                  use_cur;
		input [`ADDR_W-1:0]    pc;
		input [`WORD_W-1:0]    ir;
		begin
			form_page_addr = {(use_cur ? pc[`ADDR_W-1:`OFFSET_W] : {`PAGE_W{1'b0}}),
				ir[`IR_OFFSET_HI:`IR_OFFSET_LO]};
		end
	endfunction

	assign idle           = (state == ST_IDLE);
	assign take_mem_ref   = idle & mem_ref_start_i;
	// Memory reference wins when both strobes arrive together
	assign take_operate   = idle & ~mem_ref_start_i & operate_i;
	assign want_indirect  = instr_indirect(instr_i);
	assign want_invert    = instr_i[`OPR_INVERT_POS];
	assign want_increment = instr_i[`OPR_INCREMENT_POS];

	assign page_addr = form_page_addr(instr_cur_page(instr_i), instr_addr_i, instr_i);

	assign add_full    = add_words(sum_register_o, mem_data_i);
	assign add_result  = add_full[`WORD_W-1:0];
	assign add_carry   = add_full[`WORD_W];
	assign incremented = sum_register_o + 12'h001;
	assign inverted    = ~sum_register_o;

	assign sum_negative_o = sum_register_o[`WORD_W-1];
	assign busy_o         = ~idle;

	// Sequencer next state
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (take_mem_ref) begin
					if (want_indirect)
						next_state = ST_PTR_READ;
					else if (add_enable_i)
						next_state = ST_OPR_READ;
					else
						next_state = ST_IDLE;
				end else if (take_operate && want_increment) begin
					next_state = ST_INC;
				end
			end
			ST_PTR_READ: begin
				if (mem_valid_i) begin
					if (add_pending)
						next_state = ST_OPR_READ;
					else
						next_state = ST_IDLE;
				end
			end
			ST_OPR_READ: begin
				if (mem_valid_i)
					next_state = ST_IDLE;
			end
			ST_INC: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Add request is latched with the start, it outlives the pointer read
	always @* begin
		next_add_pending = add_pending;
		if (take_mem_ref)
			next_add_pending = add_enable_i;
	end

	// Read request stays up until the memory answers
	always @* begin
		next_mem_read = mem_read_o;
		next_mem_addr = mem_addr_o;
		case (state)
			ST_IDLE: begin
				next_mem_read = 1'b0;
				if (take_mem_ref) begin
					next_mem_addr = page_addr;
					if (want_indirect) begin
						next_mem_read = 1'b1;
					end else begin
						next_mem_read = add_enable_i;
					end
				end
			end
			ST_PTR_READ: begin
				if (mem_valid_i) begin
					next_mem_addr = mem_data_i;
					next_mem_read = add_pending;
				end
			end
			ST_OPR_READ: begin
				if (mem_valid_i)
					next_mem_read = 1'b0;
			end
			ST_INC: begin
				next_mem_read = mem_read_o;
			end
			default: begin
				next_mem_read = 1'b0;
			end
		endcase
	end

	// Effective address, flagged for one cycle
	always @* begin
		next_eff_addr       = eff_addr_o;
		next_eff_addr_valid = 1'b0;
		case (state)
			ST_IDLE: begin
				if (take_mem_ref && !want_indirect) begin
					next_eff_addr       = page_addr;
					next_eff_addr_valid = 1'b1;
				end
			end
			ST_PTR_READ: begin
				if (mem_valid_i) begin
					next_eff_addr       = mem_data_i;
					next_eff_addr_valid = 1'b1;
				end
			end
			default: begin
				next_eff_addr_valid = 1'b0;
			end
		endcase
	end

	// Sum register and link; increment leaves the link alone
	always @* begin
		next_sum  = sum_register_o;
		next_link = link_o;
		case (state)
			ST_IDLE: begin
				if (take_operate && want_invert)
					next_sum = inverted;
			end
			ST_OPR_READ: begin
				if (mem_valid_i) begin
					next_sum = add_result;
					if (add_carry)
						next_link = ~link_o;
				end
			end
			ST_INC: begin
				next_sum = incremented;
			end
			default: begin
				next_sum = sum_register_o;
			end
		endcase
	end

	// Sequencer registers
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state       <= ST_IDLE;
			add_pending <= `FLAG_RESET;
		end else begin
			state       <= next_state;
			add_pending <= next_add_pending;
		end
	end

	// Memory read port
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mem_read_o <= `FLAG_RESET;
			mem_addr_o <= `ADDR_RESET;
		end else begin
			mem_read_o <= next_mem_read;
			mem_addr_o <= next_mem_addr;
		end
	end

	// Effective address output
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			eff_addr_o       <= `ADDR_RESET;
			eff_addr_valid_o <= `FLAG_RESET;
		end else begin
			eff_addr_o       <= next_eff_addr;
			eff_addr_valid_o <= next_eff_addr_valid;
		end
	end

	// Arithmetic state
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sum_register_o <= `SUM_RESET;
			link_o         <= `LINK_RESET;
		end else begin
			sum_register_o <= next_sum;
			link_o         <= next_link;
		end
	end

endmodule // paged_address_and_add_unit

`default_nettype wire

/* File: test/paged_add_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module paged_add_chk (
	input wire logic        sys_clk_i, reset_n_i, mem_ref_start_i, add_enable_i, operate_i,
	input wire logic        mem_read_o, mem_valid_i, eff_addr_valid_o, link_o, sum_negative_o,
	input wire logic        busy_o,
	input wire logic [11:0] instr_i, instr_addr_i, mem_data_i, mem_addr_o, eff_addr_o,
	input wire logic [11:0] sum_register_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	logic [11:0] pa;
	logic        ind, ad;
	wire         go = mem_ref_start_i && !busy_o;
	wire         op = operate_i && !busy_o && !mem_ref_start_i;
	wire         rv = mem_read_o && mem_valid_i;
	// Carry kept in the 13th bit
	wire  [12:0] s13 = sum_register_o + mem_data_i;
	wire         cy = s13[12];
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pa <= 12'h000;
			ind <= 1'b0;
			ad <= 1'b0;
		end else if (go) begin
			pa <= {instr_i[7] ? instr_addr_i[11:7] : 5'h00, instr_i[6:0]};
			ind <= instr_i[8];
			ad <= add_enable_i;
		end else if (rv) begin
			ind <= 1'b0;
		end
	end
	chk_page_addr: assert property (go && !instr_i[8] |=> eff_addr_valid_o && eff_addr_o == pa)
		else $error("page address wrong");
	chk_read_addr: assert property (go && (instr_i[8] || add_enable_i) |=> mem_read_o && mem_addr_o == pa)
		else $error("read address wrong");
	chk_ind_addr: assert property (ind && rv |=> eff_addr_valid_o && eff_addr_o == $past(mem_data_i))
		else $error("pointer not used");
	chk_add_sum: assert property (ad && !ind && rv |=> sum_register_o == $past(sum_register_o) + $past(mem_data_i))
		else $error("sum wrong");
	chk_carry_link: assert property (ad && !ind && rv |=> link_o == ($past(link_o) ^ $past(cy)))
		else $error("link wrong");
	chk_negate_order: assert property (op && instr_i[5] && instr_i[0] |=> sum_register_o == ~$past(sum_register_o) ##1 sum_register_o == $past(sum_register_o) + 12'h001)
		else $error("negate wrong");
	chk_incr_late: assert property (op && !instr_i[5] && instr_i[0] |=> $stable(sum_register_o) ##1 sum_register_o == $past(sum_register_o) + 12'h001)
		else $error("increment early");
	chk_sign_bit: assert property (sum_negative_o == sum_register_o[11])
		else $error("sign wrong");
	chk_zero_negate: assert property (op && instr_i[5] && instr_i[0] && sum_register_o == 12'h000 |=> ##1 sum_register_o == 12'h000)
		else $error("zero not single");
	cover property (ind && rv);
	cover property ($rose(link_o));
	cover property (op && instr_i[5] && instr_i[0]);
	cover property (go && !instr_i[8] && !add_enable_i);
endmodule // paged_add_chk
bind paged_address_and_add_unit paged_add_chk chk_inst (
	.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .mem_ref_start_i(mem_ref_start_i),
	.add_enable_i(add_enable_i), .operate_i(operate_i), .mem_read_o(mem_read_o),
	.mem_valid_i(mem_valid_i), .eff_addr_valid_o(eff_addr_valid_o), .link_o(link_o),
	.sum_negative_o(sum_negative_o), .busy_o(busy_o), .instr_i(instr_i),
	.instr_addr_i(instr_addr_i), .mem_data_i(mem_data_i), .mem_addr_o(mem_addr_o),
	.eff_addr_o(eff_addr_o), .sum_register_o(sum_register_o));
`default_nettype wire

/* File: test/core_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_mem_model (
	input wire logic        clk_i, rd_i,
	input wire logic [11:0] addr_i,
	input wire logic [3:0]  lat_i,
	output logic            valid_o,
	output logic [11:0]     data_o
);
	logic [11:0] m [4096];
	logic [3:0]  n = 4'h0;
	initial begin
		valid_o = 1'b0;
		data_o = 12'h000;
	end
	// Data toggles between answers so stale words never look valid
	always @(posedge clk_i) begin
		valid_o <= 1'b0;
		data_o <= ~data_o;
		n <= 4'h0;
		if (rd_i && !valid_o) begin
			if (n >= lat_i) begin
				valid_o <= 1'b1;
				data_o <= m[addr_i];
			end else n <= n + 4'h1;
		end
	end
endmodule // core_mem_model
`default_nettype wire

/* File: test/paged_address_and_add_unit_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module paged_address_and_add_unit_bench;
	logic sys_clk_i = 0, reset_n_i = 0, mem_ref_start_i = 0, add_enable_i = 0, operate_i = 0;
	logic [11:0] instr_i = 0, instr_addr_i = 0, mem_addr_o, eff_addr_o, sum_register_o, mem_data_i, e;
	logic mem_read_o, mem_valid_i, eff_addr_valid_o, link_o, sum_negative_o, busy_o;
	logic [3:0] lat = 0;
	int n_fail = 0, check_count = 0, cyc = 0;
	always #20 sys_clk_i = ~sys_clk_i;
	paged_address_and_add_unit paged_address_and_add_unit_inst (
		.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .mem_ref_start_i(mem_ref_start_i),
		.add_enable_i(add_enable_i), .instr_i(instr_i), .instr_addr_i(instr_addr_i),
		.operate_i(operate_i), .mem_read_o(mem_read_o), .mem_addr_o(mem_addr_o),
		.mem_valid_i(mem_valid_i), .mem_data_i(mem_data_i), .eff_addr_o(eff_addr_o),
		.eff_addr_valid_o(eff_addr_valid_o), .sum_register_o(sum_register_o),
		.link_o(link_o), .sum_negative_o(sum_negative_o), .busy_o(busy_o));
	core_mem_model core_mem_model_inst (.clk_i(sys_clk_i), .rd_i(mem_read_o), .addr_i(mem_addr_o),
		.lat_i(lat), .valid_o(mem_valid_i), .data_o(mem_data_i));
	task automatic chk(input logic [11:0] got, exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// One instruction, held one edge, then wait for idle
	task automatic run(input logic [11:0] ins, pc, input logic mref, add);
		instr_i = ins;
		instr_addr_i = pc;
		add_enable_i = add;
		mem_ref_start_i = mref;
		operate_i = !mref;
		e = 12'hxxx;
		repeat (20) begin
			@(negedge sys_clk_i);
			mem_ref_start_i = 0;
			operate_i = 0;
			if (eff_addr_valid_o === 1'b1) e = eff_addr_o;
			if (busy_o === 1'b0) break;
		end
	endtask
	task automatic t_page0;
		core_mem_model_inst.m[12'h07f] = 12'h800;
		run(12'he21, 0, 0, 0);
		chk(sum_register_o, 12'h000);
		run(12'h27f, 12'h29c, 1, 1);
		chk(e, 12'h07f);
		chk(sum_register_o, 12'h800);
		chk({11'h000, sum_negative_o}, 12'h001);
		run(12'h27f, 12'h29c, 1, 0);
		chk(e, 12'h07f);
		chk(sum_register_o, 12'h800);
	endtask
	task automatic t_curpage;
		lat = 5;
		core_mem_model_inst.m[12'hf85] = 12'h800;
		run(12'h285, 12'hfff, 1, 1);
		chk(e, 12'hf85);
		chk(sum_register_o, 12'h000);
		chk({11'h000, link_o}, 12'h001);
	endtask
	task automatic t_indirect;
		lat = 0;
		core_mem_model_inst.m[12'h085] = 12'hfff;
		core_mem_model_inst.m[12'hfff] = 12'h003;
		core_mem_model_inst.m[12'h000] = 12'h123;
		run(12'h385, 12'h080, 1, 1);
		chk(e, 12'hfff);
		chk(sum_register_o, 12'h003);
		run(12'h300, 12'hfff, 1, 0);
		chk(e, 12'h123);
	endtask
	task automatic t_negate;
		run(12'he21, 0, 0, 0);
		chk(sum_register_o, 12'hffd);
		run(12'he20, 0, 0, 0);
		chk(sum_register_o, 12'h002);
		run(12'he01, 0, 0, 0);
		chk(sum_register_o, 12'h003);
	endtask
	always @(posedge sys_clk_i) begin
		if (++cyc > 2000) begin
			n_fail++;
			final_report();
		end
	end
	initial begin
		repeat (16) @(negedge sys_clk_i);
		reset_n_i = 1;
		t_page0();
		t_curpage();
		t_indirect();
		t_negate();
		final_report();
	end
endmodule // paged_address_and_add_unit_bench
`default_nettype wire
